// ===== design/htm_measure_ctrl.sv
// serial register port and measurement control of the humidity/temp sensor
//
// Operation
// - bit 1 start write begins humidity conversion
// - bit 0 start write begins temperature conversion
// - zero command bits leave sensors untouched
// - bit 1 stop write ends continuous humidity
// - bit 0 stop write ends continuous temperature
// - status bit 1 shows humidity converting
// - status bit 0 shows temperature converting
// - temperature result kept until next measurement
// - temperature result top bits carry crc
// - temperature bit 16 marks valid data
// - temperature value low sixteen bits, lsb first
// - humidity result top bits carry crc
// - humidity bit 16 marks valid data
// - humidity value low sixteen bits, lsb first
// - first byte access snapshots all three
// - run-mode bit selects continuous or single
`timescale 1ns/10ps
`default_nettype none
module htm_measure_ctrl
    import htm_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = HTM_DEV_ADDR, // slave address
    parameter logic [HTM_CRC_W-1:0] CRC_POLY = HTM_CRC_POLY, // crc poly
    parameter logic [HTM_CRC_W-1:0] CRC_INIT = HTM_CRC_INIT  // crc seed
) (
    input wire logic i_sys_clk, // 250 MHz system clock
    input wire logic i_rstn, // async reset, active low
    input wire logic i_scl, // serial clock pin
    input wire logic i_sda, // serial data pin level
    output logic o_sda_o, // serial data drive value
    output logic o_sda_oe, // serial data drive enable
    input wire logic [1:0] i_run_mode, // run_mode_select bits
    output logic o_t_start, // temperature conversion request
    output logic o_h_start, // humidity conversion request
    input wire logic i_t_done, // temperature conversion finished
    input wire logic [15:0] i_t_value, // temperature value
    input wire logic i_t_ok, // temperature value usable
    input wire logic i_h_done, // humidity conversion finished
    input wire logic [15:0] i_h_value, // humidity value
    input wire logic i_h_ok // humidity value usable
);

    // pin synchronisers and filtered levels
    // edges come from filtered levels
    logic [2:0] scl_sync_q; // scl stages
    logic [2:0] sda_sync_q; // sda stages
    logic scl_f_q; // filtered scl
    logic sda_f_q; // filtered sda
    logic scl_nf; // next filtered scl
    logic sda_nf; // next filtered sda
    logic scl_rise; // scl rising edge
    logic scl_fall; // scl falling edge
    logic start_cond; // bus start seen
    logic stop_cond; // bus stop seen

    // serial slave state
    htm_state_t state_q; // slave state
    logic [7:0] shift_q; // received byte
    logic [7:0] tx_q; // byte being sent
    logic [2:0] cnt_q; // bit counter
    logic full_q; // eight bits clocked
    logic rw_q; // read transfer
    logic ptr_got_q; // pointer byte received
    logic [7:0] ptr_q; // register pointer
    logic oe_q; // sda pull low
    logic wr_commit; // write byte complete
    logic load_rd; // fetch a read byte
    logic [7:0] rd_byte; // byte at pointer

    // measurement control
    // one bit per sensor, temperature in bit 0
    logic [1:0] start_req; // start command bits
    logic [1:0] stop_req; // stop command bits
    logic [1:0] done_in; // conversion done inputs
    logic [1:0] busy_q; // converting status
    logic [1:0] cont_q; // continuous mode armed
    logic [1:0] go_q; // start pulse to core
    logic [1:0] load_res; // store result

    // results and read snapshots
    // live values feed byte zero and buffers
    logic [HTM_RES_W-1:0] t_live; // live temperature result
    logic [HTM_RES_W-1:0] h_live; // live humidity result
    logic [HTM_RES_W-1:0] t_snap_q; // temperature read buffer
    logic [HTM_RES_W-1:0] h_snap_q; // humidity read buffer

    // three stage synchronisers on both pins
    // resets to idle high: no false edge
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], i_scl};
            sda_sync_q <= {sda_sync_q[1:0], i_sda};
        end
    end

    // a change counts once stages two and three agree
    assign scl_nf = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_f_q;
    assign sda_nf = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_f_q;
    assign scl_rise = scl_nf & ~scl_f_q;
    assign scl_fall = ~scl_nf & scl_f_q;
    assign start_cond = scl_f_q & scl_nf & sda_f_q & ~sda_nf;
    assign stop_cond = scl_f_q & scl_nf & ~sda_f_q & sda_nf;

    // filtered pin levels
    // about three clocks late per change
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
        end else begin
            scl_f_q <= scl_nf;
            sda_f_q <= sda_nf;
        end
    end

    // read mux; first byte of a result reads the fresh live value
    // reading that byte snapshots the whole result
    always_comb begin
        rd_byte = HTM_RD_ZERO;
        case (ptr_q)
            HTM_OFS_STATUS: rd_byte = {6'h00, busy_q};
            HTM_OFS_TEMP0: rd_byte = t_live[7:0];
            HTM_OFS_TEMP1: rd_byte = t_snap_q[15:8];
            HTM_OFS_TEMP2: rd_byte = t_snap_q[23:16];
            HTM_OFS_HUM0: rd_byte = h_live[7:0];
            HTM_OFS_HUM1: rd_byte = h_snap_q[15:8];
            HTM_OFS_HUM2: rd_byte = h_snap_q[23:16];
            default: rd_byte = HTM_RD_ZERO; // start, stop, unmapped
        endcase
    end

    // byte events used outside the slave process
    // a start or stop on that edge cancels it
    assign wr_commit = (state_q == HTM_WRITE) & scl_fall & full_q & ptr_got_q
                       & ~start_cond & ~stop_cond;
    assign load_rd = ((state_q == HTM_ADDR_ACK) & rw_q
                      | (state_q == HTM_RACK)) & scl_fall
                     & ~start_cond & ~stop_cond;

    // serial slave: address, pointer, write and read bytes
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= HTM_IDLE;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            cnt_q <= 3'h0;
            full_q <= 1'b0;
            rw_q <= 1'b0;
            ptr_got_q <= 1'b0;
            ptr_q <= 8'h00;
            oe_q <= 1'b0;
        // bus conditions override a byte
        end else if (start_cond) begin // start or repeated start
            state_q <= HTM_ADDR;
            cnt_q <= 3'h0;
            full_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (stop_cond) begin // stop frees the bus
            state_q <= HTM_IDLE;
            full_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            case (state_q)
                HTM_IDLE: begin
                    oe_q <= 1'b0;
                end
                // eight bits in, act on the next fall
                HTM_ADDR, HTM_WRITE: begin
                    if (scl_rise) begin // shift in one bit
                        shift_q <= {shift_q[6:0], sda_f_q};
                        cnt_q <= cnt_q + 3'h1;
                        full_q <= (cnt_q == 3'h7);
                    end else if (scl_fall && full_q) begin
                        full_q <= 1'b0;
                        if (state_q == HTM_WRITE) begin // ack the byte
                            oe_q <= 1'b1;
                            state_q <= HTM_WACK;
                            if (!ptr_got_q) begin
                                ptr_q <= shift_q;
                                ptr_got_q <= 1'b1;
                            end else begin // auto increment
                                ptr_q <= ptr_q + 8'h01;
                            end
                        end else if (shift_q[7:1] == DEV_ADDR) begin
                            oe_q <= 1'b1;
                            rw_q <= shift_q[0];
                            state_q <= HTM_ADDR_ACK;
                        end else begin // not our address
                            state_q <= HTM_IDLE;
                        end
                    end
                end
                // ack stands until its clock falls
                HTM_WACK: begin
                    if (scl_fall) begin // release after ack clock
                        oe_q <= 1'b0;
                        cnt_q <= 3'h0;
                        state_q <= HTM_WRITE;
                    end
                end
                // after an ack: read byte or pointer
                HTM_ADDR_ACK, HTM_RACK: begin
                    if (scl_rise && state_q == HTM_RACK && sda_f_q) begin
                        state_q <= HTM_IDLE; // master nack ends read
                    end else if (scl_fall) begin
                        cnt_q <= 3'h0;
                        if (rw_q) begin // present first bit of next byte
                            oe_q <= ~rd_byte[7];
                            tx_q <= {rd_byte[6:0], 1'b0};
                            ptr_q <= ptr_q + 8'h01;
                            state_q <= HTM_RDATA;
                        end else begin // write: next byte is pointer
                            oe_q <= 1'b0;
                            ptr_got_q <= 1'b0;
                            state_q <= HTM_WRITE;
                        end
                    end
                end
                // msb first, changes while scl low
                HTM_RDATA: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + 3'h1;
                        full_q <= (cnt_q == 3'h7);
                    end else if (scl_fall) begin
                        if (full_q) begin // release for master ack
                            full_q <= 1'b0;
                            oe_q <= 1'b0;
                            state_q <= HTM_RACK;
                        end else begin
                            oe_q <= ~tx_q[7];
                            tx_q <= {tx_q[6:0], 1'b0};
                        end
                    end
                end
                // unused codes drop back to idle
                default: begin
                    state_q <= HTM_IDLE;
                    oe_q <= 1'b0;
                end
            endcase
        end
    end

    // read buffers latch all three bytes on first byte access
    // later bytes come from the buffer
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            t_snap_q <= HTM_RST_RES;
            h_snap_q <= HTM_RST_RES;
        end else if (load_rd) begin
            if (ptr_q == HTM_OFS_TEMP0) begin
                t_snap_q <= t_live;
            end
            if (ptr_q == HTM_OFS_HUM0) begin
                h_snap_q <= h_live;
            end
        end
    end

    // command decode; only ones act, zeros and reserved bits do nothing
    // reserved bits 7:2 are never looked at
    assign start_req = (wr_commit && ptr_q == HTM_OFS_START)
                       ? shift_q[1:0] : 2'h0;
    assign stop_req = (wr_commit && ptr_q == HTM_OFS_STOP)
                      ? shift_q[1:0] : 2'h0;
    // done inputs in command bit order
    assign done_in = {i_h_done, i_t_done};

    // per sensor conversion state
    // stop only disarms the repeat; a running
    // conversion still finishes and stores
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_q <= HTM_RST_CTRL[1:0];
            cont_q <= 2'h0;
            go_q <= 2'h0;
        end else begin
            for (int i = 0; i < HTM_NUM_SENS; i++) begin
                if (start_req[i]) begin // start wins over done
                    busy_q[i] <= 1'b1;
                    cont_q[i] <= i_run_mode[i];
                    go_q[i] <= 1'b1;
                end else if (done_in[i] && busy_q[i]) begin
                    busy_q[i] <= cont_q[i] & ~stop_req[i];
                    go_q[i] <= cont_q[i] & ~stop_req[i];
                    cont_q[i] <= cont_q[i] & ~stop_req[i];
                end else begin
                    go_q[i] <= 1'b0;
                    if (stop_req[i]) begin
                        cont_q[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // result written in the cycle the single shot status drops
    // a done while idle is ignored
    assign load_res = done_in & busy_q;

    // one builder per sensor, same crc
    htm_result_reg #(
        .CRC_POLY(CRC_POLY),
        .CRC_INIT(CRC_INIT)
    ) u_temp_res (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_load(load_res[HTM_BIT_TEMP]),
        .i_value(i_t_value),
        .i_valid(i_t_ok),
        .o_result(t_live)
    );

    htm_result_reg #(
        .CRC_POLY(CRC_POLY),
        .CRC_INIT(CRC_INIT)
    ) u_hum_res (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_load(load_res[HTM_BIT_HUM]),
        .i_value(i_h_value),
        .i_valid(i_h_ok),
        .o_result(h_live)
    );

    // enable and requests straight from flops, drive value tied low; sda only ever pulled low
    // no clock stretching: scl never driven
    assign o_sda_oe = oe_q;
    assign o_sda_o = 1'b0;
    assign o_t_start = go_q[HTM_BIT_TEMP];
    assign o_h_start = go_q[HTM_BIT_HUM];

endmodule
`default_nettype wire

// ===== design/htm_pkg.sv
// shared constants and types of the humidity and temperature readout block
package htm_pkg;

    // register offsets on the serial port
    localparam logic [7:0] HTM_OFS_START = 8'h22; // measurement_start
    localparam logic [7:0] HTM_OFS_STOP = 8'h23; // measurement_stop
    localparam logic [7:0] HTM_OFS_STATUS = 8'h24; // measurement_status
    localparam logic [7:0] HTM_OFS_TEMP0 = 8'h30; // temperature_result byte 0
    localparam logic [7:0] HTM_OFS_TEMP1 = 8'h31; // temperature_result byte 1
    localparam logic [7:0] HTM_OFS_TEMP2 = 8'h32; // temperature_result byte 2
    localparam logic [7:0] HTM_OFS_HUM0 = 8'h33; // humidity_result byte 0
    localparam logic [7:0] HTM_OFS_HUM1 = 8'h34; // humidity_result byte 1
    localparam logic [7:0] HTM_OFS_HUM2 = 8'h35; // humidity_result byte 2

    // bit positions in the start, stop and status bytes
    localparam int HTM_BIT_TEMP = 0; // temperature sensor bit
    localparam int HTM_BIT_HUM = 1; // humidity sensor bit
    localparam int HTM_NUM_SENS = 2; // sensors handled

    // result layout
    localparam int HTM_RES_W = 24; // result width
    localparam int HTM_DATA_W = 16; // value field width
    localparam int HTM_VALID_BIT = 16; // valid flag position
    localparam int HTM_CRC_LSB = 17; // crc field low bit
    localparam int HTM_CRC_W = 7; // crc field width

    // reset values
    localparam logic [7:0] HTM_RST_CTRL = 8'h00; // start, stop, status
    localparam logic [HTM_RES_W-1:0] HTM_RST_RES = 24'h000000; // results
    localparam logic [7:0] HTM_RD_ZERO = 8'h00; // unmapped read value

    // crc defaults, plain choices
    localparam logic [HTM_CRC_W-1:0] HTM_CRC_POLY = 7'h09; // polynomial
    localparam logic [HTM_CRC_W-1:0] HTM_CRC_INIT = 7'h7F; // seed

    // serial slave address, arbitrary value
    localparam logic [6:0] HTM_DEV_ADDR = 7'h43; // 7-bit slave address

    // serial slave states, gray coded along the usual path
    typedef enum logic [2:0] {
        HTM_IDLE = 3'h0,
        HTM_ADDR = 3'h1,
        HTM_ADDR_ACK = 3'h3,
        HTM_WRITE = 3'h2,
        HTM_WACK = 3'h6,
        HTM_RDATA = 3'h7,
        HTM_RACK = 3'h5
    } htm_state_t;

endpackage

// ===== design/htm_result_reg.sv
// one result register: value, valid flag and crc over both
`timescale 1ns/10ps
`default_nettype none
module htm_result_reg
    import htm_pkg::*;
#(
    parameter logic [HTM_CRC_W-1:0] CRC_POLY = HTM_CRC_POLY, // generator
    parameter logic [HTM_CRC_W-1:0] CRC_INIT = HTM_CRC_INIT  // seed
) (
    input wire logic i_sys_clk, // system clock
    input wire logic i_rstn, // async reset, active low
    input wire logic i_load, // store a new measurement
    input wire logic [HTM_DATA_W-1:0] i_value, // measured value
    input wire logic i_valid, // value is valid
    output logic [HTM_RES_W-1:0] o_result // crc, valid, value
);

    // crc over valid flag then value, msb first
    function automatic logic [HTM_CRC_W-1:0] crc_calc(
        input logic [HTM_DATA_W:0] msg
    );
        logic [HTM_CRC_W-1:0] c;
        logic fb;
        c = CRC_INIT;
        fb = 1'b0;
        for (int i = HTM_DATA_W; i >= 0; i--) begin
            fb = c[HTM_CRC_W-1] ^ msg[i];
            c = {c[HTM_CRC_W-2:0], 1'b0};
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        return c;
    endfunction

    logic [HTM_RES_W-1:0] res_q; // live result

    // latest outcome stays until the next load
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            res_q <= HTM_RST_RES;
        end else if (i_load) begin
            res_q <= {crc_calc({i_valid, i_value}), i_valid, i_value};
        end
    end

    assign o_result = res_q;

endmodule
`default_nettype wire

// ===== verification/htm_measure_ctrl_sva.sv
// port checker of the humidity/temperature readout block
`timescale 1ns/10ps
`default_nettype none
module htm_measure_ctrl_sva (
    input wire logic i_sys_clk, // system clock
    input wire logic i_rstn, // async reset, active low
    input wire logic i_scl, // serial clock pin
    input wire logic i_sda, // serial data wire
    input wire logic o_sda_o, // data drive value
    input wire logic o_sda_oe, // data drive enable
    input wire logic [1:0] i_run_mode, // run mode bits
    input wire logic o_t_start, // temp request
    input wire logic o_h_start, // hum request
    input wire logic i_t_done, // temp done
    input wire logic [15:0] i_t_value, // temp value
    input wire logic i_t_ok, // temp ok
    input wire logic i_h_done, // hum done
    input wire logic [15:0] i_h_value, // hum value
    input wire logic i_h_ok // hum ok
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    // requests last one cycle
    a_tstart_one_pulse: assert property (o_t_start |=> !o_t_start)
        else $error("temp request longer than one cycle");
    a_hstart_one_pulse: assert property (o_h_start |=> !o_h_start)
        else $error("hum request longer than one cycle");
    // a command request comes at a byte end, scl low
    a_tstart_at_cmd: assert property ($rose(o_t_start) && !$past(i_t_done)
        |-> !i_scl)
        else $error("temp request outside command commit");
    a_hstart_at_cmd: assert property ($rose(o_h_start) && !$past(i_h_done)
        |-> !i_scl)
        else $error("hum request outside command commit");
    // single shot: no new request after done
    a_tsingle_no_rerun: assert property (i_t_done && !i_run_mode[0] && i_scl
        |=> !o_t_start)
        else $error("single shot temp restarted");
    a_hsingle_no_rerun: assert property (i_h_done && !i_run_mode[1] && i_scl
        |=> !o_h_start)
        else $error("single shot hum restarted");
    // open drain: drive value always low
    a_sda_open_drain: assert property (o_sda_o == 1'b0)
        else $error("data pin driven high");
    // slave data only moves while scl is low
    a_oe_still_high: assert property (i_scl && $past(i_scl, 5)
        |-> $stable(o_sda_oe))
        else $error("data enable moved while clock high");
    c_tstart: cover property (o_t_start);
    c_hstart: cover property (o_h_start);
    c_trerun: cover property (i_t_done && i_run_mode[0] ##1 o_t_start);
endmodule
bind htm_measure_ctrl htm_measure_ctrl_sva htm_measure_ctrl_sva_inst (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_run_mode(i_run_mode),
    .o_t_start(o_t_start), .o_h_start(o_h_start), .i_t_done(i_t_done),
    .i_t_value(i_t_value), .i_t_ok(i_t_ok), .i_h_done(i_h_done),
    .i_h_value(i_h_value), .i_h_ok(i_h_ok));
`default_nettype wire

// ===== verification/htm_i2c_master.sv
// serial bus master model for the register port
`timescale 1ns/10ps
`default_nettype none
module htm_i2c_master
    import htm_pkg::*;
(
    input wire logic i_sys_clk, // paces the bus
    input wire logic i_sda, // resolved data wire
    output logic o_scl, // bus clock, still high between frames
    output logic o_sda_oe // pulls data low while high
);
    int nacks = 0; // acks the slave missed
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    // quarter of the 160 ns bus period
    task automatic qtr();
        repeat (10) @(posedge i_sys_clk);
    endtask
    // one clock pulse, wire sampled while high
    task automatic pulse(output logic b);
        qtr();
        o_scl <= 1'b1;
        qtr();
        b = i_sda;
        qtr();
        o_scl <= 1'b0;
        qtr();
    endtask
    // start or repeated start
    task automatic start();
        o_sda_oe <= 1'b0;
        qtr();
        o_scl <= 1'b1;
        qtr();
        o_sda_oe <= 1'b1;
        qtr();
        o_scl <= 1'b0;
        qtr();
    endtask
    task automatic stop();
        o_sda_oe <= 1'b1;
        qtr();
        o_scl <= 1'b1;
        qtr();
        o_sda_oe <= 1'b0;
        qtr();
        qtr();
    endtask
    // byte out msb first, then the slave ack
    task automatic wbyte(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            o_sda_oe <= ~d[i];
            pulse(a);
        end
        o_sda_oe <= 1'b0;
        pulse(a);
        if (a !== 1'b0) nacks++;
    endtask
    // byte in, master ack unless last
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic a;
        o_sda_oe <= 1'b0;
        for (int i = 7; i >= 0; i--) pulse(d[i]);
        o_sda_oe <= ~last;
        pulse(a);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        start();
        wbyte({HTM_DEV_ADDR, 1'b0});
        wbyte(a);
        wbyte(d);
        stop();
    endtask
    // n bytes from a, lowest address in the low byte
    task automatic rd_reg(input logic [7:0] a, input int n,
        output logic [23:0] v);
        logic [7:0] b;
        v = 24'h000000;
        start();
        wbyte({HTM_DEV_ADDR, 1'b0});
        wbyte(a);
        start();
        wbyte({HTM_DEV_ADDR, 1'b1});
        for (int k = 0; k < n; k++) begin
            rbyte(k == n - 1, b);
            v[8*k +: 8] = b;
        end
        stop();
    endtask
endmodule
`default_nettype wire

// ===== verification/tb_htm_measure_ctrl.sv
// self-checking bench of the readout block
`timescale 1ns/10ps
`default_nettype none
module tb_htm_measure_ctrl;
    import htm_pkg::*;
    localparam int LAT = 2500; // core conversion time, clocks
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [1:0] i_run_mode = 2'h0;
    logic i_t_done = 1'b0;
    logic i_h_done = 1'b0;
    logic i_t_ok = 1'b0;
    logic i_h_ok = 1'b0;
    logic [15:0] i_t_value = 16'h0000;
    logic [15:0] i_h_value = 16'h0000;
    logic scl, m_oe, sda_oe, sda_o, t_start, h_start;
    // pulled-up wire, low if anyone pulls
    wire logic sda = m_oe ? 1'b0 : (sda_oe ? sda_o : 1'b1);
    int t_cnt = 0, h_cnt = 0, t_starts = 0, h_starts = 0;
    int t_dones = 0, h_dones = 0, ts = 0, hs = 0;
    int failures = 0, checks = 0, cycles = 0;
    logic [23:0] e;
    always #2 i_sys_clk = ~i_sys_clk;
    htm_measure_ctrl htm_measure_ctrl_inst (.i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
        .o_sda_oe(sda_oe), .i_run_mode(i_run_mode), .o_t_start(t_start),
        .o_h_start(h_start), .i_t_done(i_t_done), .i_t_value(i_t_value),
        .i_t_ok(i_t_ok), .i_h_done(i_h_done), .i_h_value(i_h_value),
        .i_h_ok(i_h_ok));
    htm_i2c_master htm_i2c_master_inst (.i_sys_clk(i_sys_clk), .i_sda(sda),
        .o_scl(scl), .o_sda_oe(m_oe));
    // sensor core stand-in: done pulse LAT clocks after a request
    always @(posedge i_sys_clk) begin
        if (t_start === 1'b1) begin
            t_cnt <= LAT;
            t_starts <= t_starts + 1;
        end else if (t_cnt > 0) t_cnt <= t_cnt - 1;
        if (h_start === 1'b1) begin
            h_cnt <= LAT;
            h_starts <= h_starts + 1;
        end else if (h_cnt > 0) h_cnt <= h_cnt - 1;
        i_t_done <= (t_cnt == 1);
        i_h_done <= (h_cnt == 1);
        if (t_cnt == 1) t_dones <= t_dones + 1;
        if (h_cnt == 1) h_dones <= h_dones + 1;
    end
    // hang guard
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 100000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // expected result: crc over {valid, value}, msb first
    function automatic logic [23:0] res(input logic ok, input logic [15:0] v);
        logic [6:0] c;
        logic [16:0] m;
        c = HTM_CRC_INIT;
        m = {ok, v};
        for (int i = 16; i >= 0; i--)
            c = {c[5:0], 1'b0} ^ ((c[6] ^ m[i]) ? HTM_CRC_POLY : 7'h00);
        return {c, ok, v};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        htm_i2c_master_inst.wr_reg(a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input int n,
        input logic [23:0] exp);
        logic [23:0] v;
        htm_i2c_master_inst.rd_reg(a, n, v);
        chk(v, exp);
    endtask
    // bounded wait for done counts
    task automatic wait_dones(input int t, input int h);
        for (int k = 0; k < 4 * LAT && (t_dones < t || h_dones < h); k++)
            @(posedge i_sys_clk);
        if (t_dones < t || h_dones < h) begin
            failures++;
            $display("MISMATCH at %0t: done pulses missing", $time);
        end
    endtask
    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        repeat (8) @(posedge i_sys_clk);
        // reset values, unmapped read
        rd_chk(HTM_OFS_STATUS, 1, 24'h000000);
        rd_chk(HTM_OFS_START, 1, 24'h000000);
        rd_chk(HTM_OFS_STOP, 1, 24'h000000);
        rd_chk(8'h50, 1, 24'h000000);
        rd_chk(HTM_OFS_TEMP0, 3, HTM_RST_RES);
        $display("test reset values done");
        // zero command bits start nothing
        wr(HTM_OFS_START, 8'h00);
        wr(HTM_OFS_STOP, 8'h00);
        rd_chk(HTM_OFS_STATUS, 1, 24'h000000);
        chk(24'(t_starts + h_starts), 24'h000000);
        $display("test zero writes done");
        // single shot on both, humidity marked invalid
        i_t_value <= 16'h1234;
        i_t_ok <= 1'b1;
        i_h_value <= 16'hA5C3;
        wr(HTM_OFS_START, 8'h03);
        rd_chk(HTM_OFS_STATUS, 1, 24'h000003);
        wait_dones(1, 1);
        rd_chk(HTM_OFS_STATUS, 1, 24'h000000);
        rd_chk(HTM_OFS_TEMP0, 3, res(1'b1, 16'h1234));
        rd_chk(HTM_OFS_HUM0, 3, res(1'b0, 16'hA5C3));
        $display("test single shot done");
        // first-byte snapshot survives a newer result
        e = res(1'b1, 16'h1234);
        rd_chk(HTM_OFS_TEMP0, 1, 24'h000034);
        i_t_value <= 16'h0BEE;
        wr(HTM_OFS_START, 8'h01);
        wait_dones(2, 1);
        rd_chk(HTM_OFS_TEMP1, 2, {8'h00, e[23:8]});
        rd_chk(HTM_OFS_TEMP0, 3, res(1'b1, 16'h0BEE));
        rd_chk(HTM_OFS_HUM0, 3, res(1'b0, 16'hA5C3));
        $display("test snapshot done");
        // continuous on both, then stopped one at a time
        i_run_mode <= 2'h3;
        wr(HTM_OFS_START, 8'h03);
        wait_dones(4, 3);
        wr(HTM_OFS_STOP, 8'h02);
        wait_dones(t_dones + 2, 0);
        hs = h_starts;
        wait_dones(t_dones + 1, 0);
        rd_chk(HTM_OFS_STATUS, 1, 24'h000001);
        chk(24'(h_starts - hs), 24'h000000);
        wait_dones(t_dones + 1, 0);
        wr(HTM_OFS_STOP, 8'h01);
        wait_dones(t_dones + 1, 0);
        ts = t_starts;
        repeat (LAT + 100) @(posedge i_sys_clk);
        rd_chk(HTM_OFS_STATUS, 1, 24'h000000);
        chk(24'(t_starts - ts), 24'h000000);
        chk(24'(t_starts - t_dones), 24'h000000);
        chk(24'(htm_i2c_master_inst.nacks), 24'h000000);
        $display("test continuous done");
        print_verdict();
    end
endmodule
`default_nettype wire
